// ### regulator_control_pkg.sv
// package: register map, field layout and carrier types for the regulator control bank
package regulator_control_pkg;

  // ==========================================================================
  // register indices, not byte offsets: byte address = 4*index
  localparam logic [7:0] REGULATOR4_CONTROL_IDX = 8'h29;
  localparam logic [7:0] REGULATOR5_CONTROL_IDX = 8'h2A;
  localparam logic [7:0] REGULATOR6_CONTROL_IDX = 8'h2B;
  localparam logic [7:0] REGULATOR7_CONTROL_IDX = 8'h2C;
  localparam int         NUM_REGULATORS         = 4;
  localparam int         FIRST_REGULATOR        = 4;

  // ==========================================================================
  // field positions
  localparam int ENABLE_BIT          = 0;
  localparam int ENABLE_SRC_LSB      = 1;
  localparam int PULLDOWN_DIS_BIT    = 3;
  localparam int VSEL_BIT            = 4;
  localparam int VOLT_SRC_LSB        = 5;
  localparam int SEQ_TARGET_BIT      = 7;

  // ==========================================================================
  // reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // ==========================================================================
  // pin source encodings
  localparam logic [1:0] SRC_SEQUENCER = 2'h0;
  localparam logic [1:0] SRC_PIN1      = 2'h1;
  localparam logic [1:0] SRC_PIN2      = 2'h2;
  localparam logic [1:0] SRC_PIN13     = 2'h3;

  typedef struct packed {
    logic       sequencer_target_enable;
    logic [1:0] voltage_select_pin_source;
    logic       voltage_setting_select;
    logic       pulldown_disable;
    logic [1:0] enable_pin_source;
    logic       regulator_enable;
  } control_reg_type;

  // three control input pins: pin 1, pin 2 and pin 13
  typedef struct packed {
    logic pin13;
    logic pin2;
    logic pin1;
  } control_pins_type;

  // per-regulator outputs toward the analog side
  typedef struct packed {
    logic enable;
    logic pulldown_on;
    logic use_setting_b;
    logic ramp;
  } regulator_drive_type;

endpackage

// ### pin_edge_detect.sv
// rising and falling edge detector for the control input pins
`timescale 1ns/1ns
module pin_edge_detect #(
  parameter int WIDTH = 3
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_level,
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_fall
);

  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;
  logic             armed_q;
  logic             armed_d;

  // ==========================================================================
  // history
  always_comb begin
    prev_d  = i_level;
    armed_d = 1'b1;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prev_q  <= '0;
      armed_q <= 1'b0;
    end else begin
      prev_q  <= prev_d;
      armed_q <= armed_d;
    end
  end

  // no edge reported on the first cycle: the reset history is not a real level
  assign o_rise = armed_q ? (i_level & ~prev_q) : '0;
  assign o_fall = armed_q ? (~i_level & prev_q) : '0;

endmodule

// ### regulator_channel.sv
// one regulator control register with its pin-driven enable and voltage select
`timescale 1ns/1ns
module regulator_channel
  import regulator_control_pkg::*;
#(
  parameter bit HAS_VSEL = 1'b1
) (
  input  wire logic                                   i_sys_clk,
  input  wire logic                                   i_rst_n,
  input  wire logic                                   i_wr,
  input  wire logic [7:0]                             i_wdata,
  input  wire logic                                   i_seq_apply,
  input  wire logic [2:0]                             i_rise,
  input  wire logic [2:0]                             i_fall,
  output regulator_control_pkg::control_reg_type      o_reg,
  output regulator_control_pkg::regulator_drive_type  o_drive
);

  control_reg_type     reg_q;
  control_reg_type     reg_d;
  regulator_drive_type drive_d;
  logic                en_rise;
  logic                en_fall;
  logic                v_rise;
  logic                v_fall;

  function automatic logic pick(input logic [1:0] src, input logic [2:0] ev);
    case (src)
      SRC_PIN1:  pick = ev[0];
      SRC_PIN2:  pick = ev[1];
      SRC_PIN13: pick = ev[2];
      default:   pick = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // register next state
  always_comb begin
    en_rise = pick(reg_q.enable_pin_source, i_rise);
    en_fall = pick(reg_q.enable_pin_source, i_fall);
    v_rise  = pick(reg_q.voltage_select_pin_source, i_rise);
    v_fall  = pick(reg_q.voltage_select_pin_source, i_fall);
    reg_d   = reg_q;
    if (i_wr) begin
      reg_d = control_reg_type'(i_wdata);
      if (!HAS_VSEL) begin
        reg_d.voltage_setting_select = 1'b0;
      end
    end else begin
      // sequencer only owns the enable when no pin source is chosen
      if (i_seq_apply && reg_q.enable_pin_source == SRC_SEQUENCER) begin
        reg_d.regulator_enable = reg_q.sequencer_target_enable;
      end
      if (en_rise) begin
        reg_d.regulator_enable = 1'b1;
      end else if (en_fall) begin
        reg_d.regulator_enable = 1'b0;
      end
      if (HAS_VSEL && v_rise) begin
        reg_d.voltage_setting_select = 1'b0;
      end else if (HAS_VSEL && v_fall) begin
        reg_d.voltage_setting_select = 1'b1;
      end
    end
  end

  // ==========================================================================
  // drive: regulator 4 has no select bit, so its pin choice lives in a private flop
  logic vb4_q;
  logic vb4_d;
  always_comb begin
    vb4_d = vb4_q;
    if (!HAS_VSEL && v_rise) begin
      vb4_d = 1'b0;
    end else if (!HAS_VSEL && v_fall) begin
      vb4_d = 1'b1;
    end
    drive_d.enable        = reg_d.regulator_enable;
    drive_d.pulldown_on   = !reg_d.regulator_enable && !reg_d.pulldown_disable;
    drive_d.use_setting_b = HAS_VSEL ? reg_d.voltage_setting_select : vb4_d;
    drive_d.ramp          = !HAS_VSEL;
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      reg_q   <= control_reg_type'(CONTROL_RESET);
      vb4_q   <= 1'b0;
      o_drive <= '0;
    end else begin
      reg_q   <= reg_d;
      vb4_q   <= vb4_d;
      o_drive <= drive_d;
    end
  end

  assign o_reg = reg_q;

endmodule

// ### regulator_control_regs.sv
// apb register bank controlling four linear regulators (numbered 4 to 7)
//
// Summary of operation
// - enable bit turns regulator on or off
// - bit 7 is sequencer target enable state
// - pull-down active while disabled unless bit 3
// - selected pin edges enable or disable regulator
// - source codes: sequencer, pin1, pin2, pin13
// - pin rise selects A, fall selects B
// - regulators 5 to 7 change voltage immediately
// - bit 4 picks setting A or B on regulators 5 to 7
`timescale 1ns/1ns
module regulator_control_regs
  import regulator_control_pkg::*;
(
  input  wire logic                                     i_sys_clk,
  input  wire logic                                     i_rst_n,
  input  wire logic                                     i_psel,
  input  wire logic                                     i_penable,
  input  wire logic                                     i_pwrite,
  input  wire logic [11:0]                              i_paddr,
  input  wire logic [31:0]                              i_pwdata,
  input  wire logic                                     i_seq_apply,
  input  regulator_control_pkg::control_pins_type       i_pins,
  output logic      [31:0]                              o_prdata,
  output logic                                          o_pready,
  output logic                                          o_pslverr,
  output regulator_control_pkg::regulator_drive_type [3:0] o_drive
);

  import regulator_control_pkg::*;

  // ==========================================================================
  // apb decode: zero wait state, response registered one cycle after setup
  logic [31:0]     prdata_q;
  logic [31:0]     prdata_d;
  logic            pready_q;
  logic            pready_d;
  logic            pslverr_q;
  logic            pslverr_d;
  logic [3:0]      wr;
  logic            hit;
  logic [1:0]      sel;
  logic [2:0]      rise;
  logic [2:0]      fall;
  control_reg_type regs [NUM_REGULATORS];
  regulator_drive_type drv [NUM_REGULATORS];

  logic        setup;
  logic [7:0]  idx;

  always_comb begin
    setup = i_psel && !i_penable;
    idx   = i_paddr[9:2];
    hit   = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0) &&
            (idx >= REGULATOR4_CONTROL_IDX) && (idx <= REGULATOR7_CONTROL_IDX);
    sel   = 2'(idx - REGULATOR4_CONTROL_IDX);
    wr    = '0;
    // write commits at the access edge where pready is sampled high
    if (i_psel && i_penable && pready_q && i_pwrite && hit) begin
      wr[sel] = 1'b1;
    end
    pready_d  = setup;
    pslverr_d = setup && !hit;
    prdata_d  = prdata_q;
    if (setup) begin
      prdata_d = (hit && !i_pwrite) ? {24'h000000, 8'(regs[sel])} : 32'h00000000;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign o_prdata  = prdata_q;
  assign o_pready  = pready_q;
  assign o_pslverr = pslverr_q;

  // ==========================================================================
  // pin edges, shared by all four channels
  pin_edge_detect #(
    .WIDTH (3)
  ) i_pin_edge_detect (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_level   (i_pins),
    .o_rise    (rise),
    .o_fall    (fall)
  );

  // ==========================================================================
  // channels; index 0 is regulator 4 which ramps and has no select bit
  for (genvar g = 0; g < NUM_REGULATORS; g++) begin : g_chan
    regulator_channel #(
      .HAS_VSEL (g != 0)
    ) i_regulator_channel (
      .i_sys_clk   (i_sys_clk),
      .i_rst_n     (i_rst_n),
      .i_wr        (wr[g]),
      .i_wdata     (i_pwdata[7:0]),
      .i_seq_apply (i_seq_apply),
      .i_rise      (rise),
      .i_fall      (fall),
      .o_reg       (regs[g]),
      .o_drive     (drv[g])
    );
    assign o_drive[g] = drv[g];
  end

endmodule

// ### regulator_control_monitor.sv
// checker: apb timing and drive relations of the regulator control bank
`timescale 1ns/1ns
module regulator_control_monitor
  import regulator_control_pkg::*;
(
  input wire logic         i_sys_clk,
  input wire logic         i_rst_n,
  input wire logic         i_psel,
  input wire logic         i_penable,
  input wire logic         i_pwrite,
  input wire logic [11:0]  i_paddr,
  input wire logic [31:0]  i_pwdata,
  input wire logic         i_seq_apply,
  input wire logic [31:0]  o_prdata,
  input wire logic         o_pready,
  input wire logic         o_pslverr,
  input regulator_control_pkg::regulator_drive_type [3:0] o_drive
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  logic pd_clash;
  logic mapped;
  always_comb begin
    pd_clash = 1'b0;
    for (int k = 0; k < 4; k++) begin
      pd_clash = pd_clash | (o_drive[k].enable & o_drive[k].pulldown_on);
    end
    mapped = i_paddr >= 12'h0A4 && i_paddr <= 12'h0B0 && i_paddr[1:0] == 2'h0;
  end
  // ==========
  // sequences
  sequence setup_s;
    i_psel && !i_penable;
  endsequence
  // pin source fields cleared, so no pin edge can move the bits afterwards
  sequence commit_s(logic [11:0] a);
    i_psel && i_penable && o_pready && i_pwrite && i_paddr == a
      && i_pwdata[6:5] == 2'h0 && i_pwdata[2:1] == 2'h0;
  endsequence
  // ==========
  // assertions
  a_pready_after_setup: assert property (setup_s |=> o_pready)
    else $error("no pready after setup");
  a_pready_one_cycle: assert property (o_pready |=> !o_pready)
    else $error("pready longer than one cycle");
  a_pready_in_access: assert property (o_pready |-> i_psel && i_penable)
    else $error("pready outside access phase");
  a_slverr_decode: assert property (setup_s |=> o_pslverr == !mapped)
    else $error("pslverr wrong for address");
  a_rdata_upper_zero: assert property (
      o_pready && !i_pwrite |-> o_prdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_enable_follows_write: assert property (
      commit_s(12'h0A4) ##1 !i_seq_apply |=> o_drive[0].enable == $past(i_pwdata[0], 2))
    else $error("enable does not follow write");
  a_vsel_follows_write: assert property (
      commit_s(12'h0A8) |=> ##1 o_drive[1].use_setting_b == $past(i_pwdata[4], 2))
    else $error("setting select does not follow write");
  a_pulldown_only_off: assert property (!pd_clash)
    else $error("pull-down on an enabled output");
  a_no_ramp_others: assert property (
      !(o_drive[1].ramp || o_drive[2].ramp || o_drive[3].ramp))
    else $error("ramp flagged on an immediate regulator");
endmodule
bind regulator_control_regs regulator_control_monitor i_mon (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
  .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_seq_apply(i_seq_apply),
  .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .o_drive(o_drive));

// ### tb_regulator_control_regs.sv
// testbench: register access, sequencer and pin control of the regulator bank
`timescale 1ns/1ns
module tb_regulator_control_regs;
  import regulator_control_pkg::*;
  logic                      clk = 1'b0;
  logic                      rst_n = 1'b0;
  logic                      psel = 1'b0;
  logic                      pen = 1'b0;
  logic                      pwr = 1'b0;
  logic                      seq = 1'b0;
  logic                      pready;
  logic                      pslverr;
  logic                      slv;
  logic [11:0]               paddr = 12'h000;
  logic [31:0]               pwdata = 32'h0;
  logic [31:0]               prdata;
  logic [31:0]               rd;
  logic [31:0]               rng = 32'h0000B8A1;
  logic [7:0]                v;
  logic [11:0]               bad [3] = '{12'h0A0, 12'h0B4, 12'h0A6};
  control_pins_type          pins = 3'h0;
  regulator_drive_type [3:0] drive;
  int                        err_total = 0;
  int                        cmp_count = 0;
  int                        cyc = 0;
  int                        k;
  regulator_control_regs i_regulator_control_regs (
    .i_sys_clk(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
    .i_paddr(paddr), .i_pwdata(pwdata), .i_seq_apply(seq), .i_pins(pins),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_drive(drive));
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========
  // helpers
  function logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function logic [11:0] ra(int n);
    return {2'h0, REGULATOR4_CONTROL_IDX + 8'(n), 2'h0};
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    // only the bench timeout bounds this wait
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  // regulator 4 keeps no bit 4, it reads back as zero
  task automatic rd_chk(input int n, input logic [7:0] e);
    apb(1'b0, ra(n), 32'h0);
    check(rd, {24'h0, n == 0 ? e & 8'hEF : e});
  endtask
  task automatic dr_chk(input int n, input logic [7:0] w, input logic b);
    check(32'(drive[n]), {28'h0, w[0], !w[0] && !w[3], b, n == 0});
  endtask
  task automatic pulse();
    @(posedge clk);
    seq <= 1'b1;
    @(posedge clk);
    seq <= 1'b0;
  endtask
  task automatic pins_to(input logic [2:0] p, input logic [7:0] e, input logic hb);
    @(posedge clk);
    pins <= p;
    repeat (4) @(posedge clk);
    // sequencer must leave a pin-owned enable alone
    pulse();
    for (int m = 0; m < 4; m++) begin
      rd_chk(m, e);
      dr_chk(m, e, m == 0 ? hb : e[4]);
    end
  endtask
  task automatic end_of_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // ==========
  // scenarios
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 4; k++) begin
      rd_chk(k, 8'h00);
      dr_chk(k, 8'h00, 1'b0);
    end
    // pins stay idle here, so only host writes move the bits
    repeat (24) begin
      k = rnd() % 4;
      v = 8'(rnd());
      apb(1'b1, ra(k), {24'(rnd()), v});
      repeat (2) @(posedge clk);
      dr_chk(k, v, k == 0 ? 1'b0 : v[4]);
      rd_chk(k, v);
    end
    for (k = 0; k < 4; k++) apb(1'b1, ra(k), 32'h18);
    for (int j = 0; j < 3; j++) begin
      apb(1'b1, bad[j], 32'hFF);
      check(slv, 1'b1);
      apb(1'b0, bad[j], 32'h0);
      check(rd, 32'h0);
      check(slv, 1'b1);
    end
    for (k = 0; k < 4; k++) rd_chk(k, 8'h18);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, ra(k), 32'h80);
      pulse();
      rd_chk(k, 8'h81);
      apb(1'b1, ra(k), 32'h01);
      pulse();
      rd_chk(k, 8'h00);
    end
    for (int c = 1; c < 4; c++) begin
      v = {1'b0, 2'(c), 2'h2, 2'(c), 1'b0};
      for (k = 0; k < 4; k++) apb(1'b1, ra(k), {24'h0, v});
      pins_to(~(3'h1 << (c - 1)), v, c > 1);
      pins_to(3'h7, v & 8'hEF | 8'h01, 1'b0);
      pins_to(3'h0, v, 1'b1);
    end
    // mid-run reset with pins high: no edge is seen after reset, so the hidden select of regulator 4 stays clear
    @(posedge clk);
    pins <= 3'h7;
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    for (k = 0; k < 4; k++) begin
      rd_chk(k, 8'h00);
      dr_chk(k, 8'h00, 1'b0);
    end
    end_of_test();
  end
endmodule
